// ==== core/imsc_top.sv ====
// Overview of operation
// - Only enabled sources drive the interrupt line
// - Timeout and data sources, any combination
// - Status readable raw or masked, same layout
// - Line state: data bit 1, clock bit 0
// - Seven-bit target address plus read flag
// - Twelve-bit timeout, upper eight programmable, write enables
// - Timeout counts bus periods of clock low
// - Override drives software acknowledge value
// - Acknowledge choice used only under override
// - Slot zero primary, slot one secondary
// - Responder data holds last received byte
// - Responder sends software byte on read
// - Disabled responder ignores bus
// - Initiator reports none, address, data, arbitration
// - Responder compares address with own address
// - Responder reports write, read, first byte, second
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module imsc_top
  import imsc_pkg::*;
#(
  parameter int unsigned QTR_CYC_P = QTR_CYC  // Cycles per quarter bus period
)(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Interrupt
  output logic             irq_out,
  // Bus pins
  input  wire logic        scl_in,
  output logic             scl_out_out,
  output logic             scl_oe_out,
  input  wire logic        sda_in,
  output logic             sda_out_out,
  output logic             sda_oe_out
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  localparam logic [15:0] QTR_LAST = 16'(QTR_CYC_P - 1);

  typedef struct packed {
    logic             wreq;     // Waitrequest
    logic [31:0]      rdata;    // Read data
    logic             irq;
    logic [2:0]       scl_s;    // Clock pin synchroniser
    logic [2:0]       sda_s;    // Data pin synchroniser
    logic             scl_f;    // Filtered clock level
    logic             sda_f;    // Filtered data level
    logic [7:0]       taddr;    // target_address and direction
    logic             view;     // masked_view_select
    logic [7:0]       mdata;
    logic [1:0]       merr;
    logic             busy;
    imsc_mst_t        mst;
    logic [1:0]       mph;      // Quarter of the bit
    logic [2:0]       mbit;
    logic             mbyte;    // Zero: address byte, one: data byte
    logic [7:0]       msh;
    logic             mscl;     // Initiator pulls clock low
    logic             msda;     // Initiator pulls data low
    logic [15:0]      qdiv;
    logic [1:0]       tph;
    logic [7:0]       tmo_val;  // timeout_count
    logic             tmo_en;
    logic [11:0]      tmo_cnt;
    logic [IRQ_W-1:0] raw;
    logic [IRQ_W-1:0] mask;     // irq_source_mask
    logic [6:0]       own1;
    logic [6:0]       own2;
    logic             sen;
    logic             sovr;
    logic             sackv;
    logic [7:0]       stx;
    logic             scl_oe;
    logic             sda_oe;
  } imsc_st_t;

  localparam imsc_st_t ST_RST = '{wreq: 1'b1, scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1,
                                  sda_f: 1'b1, mst: M_IDLE, taddr: RST_TADDR,
                                  tmo_val: RST_TMO, own1: RST_OWN, own2: RST_OWN,
                                  mask: RST_MASK, default: '0};

  imsc_st_t         q;          // Registered state
  imsc_st_t         n;          // Next state
  logic             scl_new;    // Clock level after this cycle's filter
  logic             sda_new;    // Data level after this cycle's filter
  logic             scl_rise;
  logic             scl_fall;
  logic             start_c;
  logic             stop_c;
  logic             resp_pull;  // Responder pulls data low
  logic [7:0]       resp_rx;
  logic             resp_stb;
  logic [3:0]       resp_stat;
  logic [5:0]       a;          // Word-aligned address
  logic [31:0]      rd_val;
  logic             rd_go;
  logic             wr_go;
  logic             start_req;
  logic             qtick;
  logic             ptick;
  logic             reading;
  logic [IRQ_W-1:0] set_v;
  logic [IRQ_W-1:0] clr_v;

  ////////////////////////////////////////////////////////////////////////////
  // Pin filter and bus events; a level counts once stages two and three agree
  assign scl_new  = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
  assign sda_new  = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
  assign scl_rise = scl_new & ~q.scl_f;
  assign scl_fall = ~scl_new & q.scl_f;
  // Start and stop: data moves while the clock stays high
  assign start_c  = q.scl_f & scl_new & q.sda_f & ~sda_new;
  assign stop_c   = q.scl_f & scl_new & ~q.sda_f & sda_new;

  ////////////////////////////////////////////////////////////////////////////
  // Responder engine
  imsc_resp imsc_resp_inst (
    .clk_sys_in  (clk_sys_in),
    .resetn_in   (resetn_in),
    .sda_in      (q.sda_f),
    .scl_rise_in (scl_rise),
    .scl_fall_in (scl_fall),
    .start_in    (start_c),
    .stop_in     (stop_c),
    .enable_in   (q.sen),
    .own1_in     (q.own1),
    .own2_in     (q.own2),
    .ack_ovr_in  (q.sovr),
    .ack_val_in  (q.sackv),
    .tx_byte_in  (q.stx),
    .sda_pull_out(resp_pull),
    .rx_byte_out (resp_rx),
    .rx_stb_out  (resp_stb),
    .status_out  (resp_stat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block
  always_comb begin
    n         = q;
    set_v     = '0;
    clr_v     = '0;
    start_req = 1'b0;
    rd_val    = 32'h0;
    a         = {avs_address_in[5:2], 2'b00};
    reading   = q.mbyte & q.taddr[TA_DIR];

    // Synchroniser shift and filtered levels
    n.scl_s = {q.scl_s[1:0], scl_in};
    n.sda_s = {q.sda_s[1:0], sda_in};
    n.scl_f = scl_new;
    n.sda_f = sda_new;

    // Quarter-period enable, and one enable per full bus period
    qtick  = (q.qdiv == QTR_LAST);
    ptick  = qtick && (q.tph == 2'h3);
    n.qdiv = qtick ? 16'h0 : q.qdiv + 16'h1;
    if (qtick) begin
      n.tph = q.tph + 2'h1;
    end

    // Read view; unmapped words read zero
    case (a)
      OFS_TADDR: rd_val[7:0] = q.taddr;
      OFS_MCTRL: begin
        rd_val[MC_VIEW]     = q.view;
        rd_val[MC_BUSY]     = q.busy;
        rd_val[MC_ERR +: 2] = q.merr;
      end
      OFS_MDATA: rd_val[7:0] = q.mdata;
      OFS_TMO:   rd_val[7:0] = q.tmo_val;
      OFS_ISTAT: rd_val[IRQ_W-1:0] = q.view ? (q.raw & q.mask) : q.raw;
      OFS_IMASK: rd_val[IRQ_W-1:0] = q.mask;
      OFS_LINE: begin
        rd_val[LS_SDA] = q.sda_f;
        rd_val[LS_SCL] = q.scl_f;
      end
      OFS_SADDR: begin
        rd_val[6:0]          = q.own1;
        rd_val[SA_OWN2 +: 7] = q.own2;
      end
      OFS_SCTRL: rd_val[2:0] = {q.sackv, q.sovr, q.sen};
      OFS_SDATA: rd_val[7:0] = resp_rx;
      OFS_SSTAT: rd_val[3:0] = resp_stat;
      default:   rd_val = 32'h0;
    endcase

    // Bus slave: one wait cycle, then the access completes
    n.wreq = 1'b1;
    rd_go  = avs_read_in & ~q.wreq;
    wr_go  = avs_write_in & ~q.wreq & avs_byteenable_in[0];
    if ((avs_read_in || avs_write_in) && q.wreq) begin
      n.wreq  = 1'b0;
      n.rdata = avs_read_in ? rd_val : 32'h0;
    end

    // Reading status clears the bits it showed
    // Clear what was captured into the read data, so an event landing in the wait cycle survives
    if (rd_go && a == OFS_ISTAT) begin
      clr_v = q.rdata[IRQ_W-1:0];
    end

    // Register writes; every writable field sits in byte lane zero
    if (wr_go) begin
      case (a)
        OFS_TADDR: n.taddr = avs_writedata_in[7:0];
        OFS_MCTRL: begin
          n.view    = avs_writedata_in[MC_VIEW];
          start_req = avs_writedata_in[MC_START];
        end
        OFS_MDATA: n.mdata = avs_writedata_in[7:0];
        OFS_TMO: begin
          n.tmo_val = avs_writedata_in[7:0];
          n.tmo_en  = 1'b1;
        end
        OFS_ISTAT: clr_v = clr_v | avs_writedata_in[IRQ_W-1:0];
        OFS_IMASK: n.mask = avs_writedata_in[IRQ_W-1:0];
        OFS_SADDR: begin
          if (avs_writedata_in[SA_SLOT]) begin
            n.own2 = avs_writedata_in[6:0];
          end else begin
            n.own1 = avs_writedata_in[6:0];
          end
        end
        OFS_SCTRL: begin
          n.sen   = avs_writedata_in[SC_EN];
          n.sovr  = avs_writedata_in[SC_OVR];
          n.sackv = avs_writedata_in[SC_ACKV];
        end
        OFS_SDATA: n.stx = avs_writedata_in[7:0];
        default: ;
      endcase
    end

    // Initiator engine; a start request while busy is ignored
    if (q.mst == M_IDLE) begin
      if (start_req) begin
        n.mst   = M_START;
        n.mph   = 2'h0;
        n.mbit  = 3'h0;
        n.mbyte = 1'b0;
        n.msh   = q.taddr;
        n.merr  = ERR_NONE;
        n.busy  = 1'b1;
      end
    end else if (qtick) begin
      n.mph = q.mph + 2'h1;
      case (q.mst)
        M_START: begin
          if (q.mph == 2'h1) n.msda = 1'b1;
          if (q.mph == 2'h2) n.mscl = 1'b1;
          if (q.mph == 2'h3) n.mst = M_BIT;
        end
        M_BIT: begin
          // Data changes only while the clock is held low
          if (q.mph == 2'h0) n.msda = reading ? 1'b0 : ~q.msh[7];
          if (q.mph == 2'h1) n.mscl = 1'b0;
          if (q.mph == 2'h2) begin
            if (!q.scl_f) begin
              // Another party stretches the clock
              n.mph = q.mph;
            end else if (!reading && !q.msda && !q.sda_f) begin
              // Released a one but the line is low: lost the bus
              n.merr        = ARBITRATION_LOST_ERROR;
              n.mst         = M_IDLE;
              n.busy        = 1'b0;
              n.msda        = 1'b0;
              n.mscl        = 1'b0;
              set_v[IRQ_MDAT] = 1'b1;
            end else begin
              n.msh = {q.msh[6:0], q.sda_f};
            end
          end
          if (q.mph == 2'h3 && q.mst == n.mst) begin
            n.mscl = 1'b1;
            n.mbit = q.mbit + 3'h1;
            if (q.mbit == 3'h7) n.mst = M_ACK;
          end
        end
        M_ACK: begin
          // Data line released: sampled after a send, a refusal after a read
          if (q.mph == 2'h0) n.msda = 1'b0;
          if (q.mph == 2'h1) n.mscl = 1'b0;
          if (q.mph == 2'h2) begin
            if (!q.scl_f) begin
              n.mph = q.mph;
            end else if (!reading && q.sda_f) begin
              n.merr = q.mbyte ? ERR_DATA_NACK : ERR_ADDR_NACK;
            end
          end
          if (q.mph == 2'h3) begin
            n.mscl = 1'b1;
            if (reading) n.mdata = q.msh;
            if (q.merr != ERR_NONE || q.mbyte) begin
              n.mst = M_STOP;
            end else begin
              n.mbyte = 1'b1;
              n.mbit  = 3'h0;
              n.msh   = q.mdata;
              n.mst   = M_BIT;
            end
          end
        end
        M_STOP: begin
          if (q.mph == 2'h0) n.msda = 1'b1;
          if (q.mph == 2'h1) n.mscl = 1'b0;
          if (q.mph == 2'h2) begin
            if (!q.scl_f) n.mph = q.mph;
            else n.msda = 1'b0;
          end
          if (q.mph == 2'h3) begin
            n.mst           = M_IDLE;
            n.busy          = 1'b0;
            set_v[IRQ_MDAT] = 1'b1;
          end
        end
        default: n.mst = M_IDLE;
      endcase
    end

    // Clock-low timeout in whole bus periods; saturates rather than wrapping
    if (q.scl_f) begin
      n.tmo_cnt = 12'h0;
    end else if (ptick && q.tmo_cnt != 12'hFFF) begin
      n.tmo_cnt = q.tmo_cnt + 12'h1;
      if (q.tmo_en && n.tmo_cnt == {q.tmo_val, 4'h0}) begin
        set_v[IRQ_TMO] = 1'b1;
      end
    end

    // Responder byte event
    set_v[IRQ_SRX] = resp_stb;

    // Sticky status: a new event wins over a clear in the same cycle
    n.raw = (q.raw & ~clr_v) | set_v;
    n.irq = |(n.raw & n.mask);

    // Open-drain drive: enable means pull low
    n.scl_oe = n.mscl;
    n.sda_oe = n.msda | resp_pull;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata_out    = q.rdata;
  assign avs_waitrequest_out = q.wreq;
  assign irq_out             = q.irq;
  assign scl_out_out         = q.scl_oe & 1'b0;
  assign scl_oe_out          = q.scl_oe;
  assign sda_out_out         = q.sda_oe & 1'b0;
  assign sda_oe_out          = q.sda_oe;
endmodule // imsc_top
`default_nettype wire

// ==== include/imsc_pkg.sv ====
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Shared constants of the two-wire bus controller
////////////////////////////////////////////////////////////////////////////////
package imsc_pkg;
  // System clock period and standard bus period
  localparam int unsigned SYS_PERIOD_NS = 25;
  localparam int unsigned BUS_PERIOD_NS = 10000;
  // System cycles per quarter of a bus clock period
  localparam int unsigned QTR_CYC       = BUS_PERIOD_NS / (4 * SYS_PERIOD_NS);

  // Register byte offsets
  localparam logic [5:0] OFS_TADDR = 6'h00;  // Target address and direction
  localparam logic [5:0] OFS_MCTRL = 6'h04;  // Initiator control and state
  localparam logic [5:0] OFS_MDATA = 6'h08;  // Initiator data byte
  localparam logic [5:0] OFS_TMO   = 6'h0C;  // Clock-low timeout
  localparam logic [5:0] OFS_ISTAT = 6'h10;  // Interrupt status
  localparam logic [5:0] OFS_IMASK = 6'h14;  // Interrupt enable mask
  localparam logic [5:0] OFS_LINE  = 6'h18;  // Live line levels
  localparam logic [5:0] OFS_SADDR = 6'h1C;  // Responder own addresses
  localparam logic [5:0] OFS_SCTRL = 6'h20;  // Responder control
  localparam logic [5:0] OFS_SDATA = 6'h24;  // Responder data byte
  localparam logic [5:0] OFS_SSTAT = 6'h28;  // Responder status

  // Field positions
  localparam int TA_DIR   = 0;   // read_direction_flag
  localparam int MC_START = 0;   // Write one to start a transaction
  localparam int MC_VIEW  = 1;   // masked_view_select
  localparam int MC_BUSY  = 2;   // Initiator busy
  localparam int MC_ERR   = 4;   // Two-bit error code
  localparam int IRQ_TMO  = 0;   // Clock-low timeout source
  localparam int IRQ_MDAT = 1;   // Initiator data source
  localparam int IRQ_SRX  = 2;   // Responder byte received
  localparam int IRQ_W    = 3;
  localparam int LS_SCL   = 0;
  localparam int LS_SDA   = 1;
  localparam int SA_SLOT  = 7;   // address_slot_select
  localparam int SA_OWN2  = 8;   // Secondary address read position
  localparam int SC_EN    = 0;
  localparam int SC_OVR   = 1;   // responder_ack_override
  localparam int SC_ACKV  = 2;   // One acknowledges, zero refuses
  localparam int SS_RREQ  = 0;
  localparam int SS_TREQ  = 1;
  localparam int SS_FBR   = 2;
  localparam int SS_OWN2  = 3;

  // Initiator error codes
  localparam logic [1:0] ERR_NONE               = 2'h0;
  localparam logic [1:0] ERR_ADDR_NACK          = 2'h1;
  localparam logic [1:0] ERR_DATA_NACK          = 2'h2;
  localparam logic [1:0] ARBITRATION_LOST_ERROR = 2'h3;

  // Reset values
  localparam logic [7:0]       RST_TADDR = 8'h00;
  localparam logic [7:0]       RST_TMO   = 8'h00;
  localparam logic [6:0]       RST_OWN   = 7'h00;
  localparam logic [IRQ_W-1:0] RST_MASK  = 3'h0;

  // State machines
  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} imsc_mst_t;
  typedef enum logic [2:0] {R_IDLE, R_ADDR, R_AACK, R_RX, R_RACK, R_TX, R_TACK} imsc_rst_t;
endpackage
`default_nettype wire

// ==== core/imsc_resp.sv ====
`timescale 1ns/1ps
`default_nettype none
module imsc_resp
  import imsc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  // Filtered bus level and events
  input  wire logic       sda_in,
  input  wire logic       scl_rise_in,
  input  wire logic       scl_fall_in,
  input  wire logic       start_in,
  input  wire logic       stop_in,
  // Software settings
  input  wire logic       enable_in,
  input  wire logic [6:0] own1_in,
  input  wire logic [6:0] own2_in,
  input  wire logic       ack_ovr_in,
  input  wire logic       ack_val_in,
  input  wire logic [7:0] tx_byte_in,
  // Results
  output logic            sda_pull_out,
  output logic [7:0]      rx_byte_out,
  output logic            rx_stb_out,
  output logic [3:0]      status_out
);
  // Whole responder state
  typedef struct packed {
    imsc_rst_t  st;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic       full;   // Byte complete, or master acknowledged
    logic       first;  // Next byte is the first after the address
    logic       pull;
    logic [7:0] rx;
    logic       stb;
    logic [3:0] stat;
  } imsc_rs_t;

  imsc_rs_t q_r;   // Registered state
  imsc_rs_t q_nxt; // Next state
  logic     ackd;  // Level of the acknowledge decision

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    q_nxt     = q_r;
    q_nxt.stb = 1'b0;
    ackd      = ack_ovr_in ? ack_val_in : 1'b1;
    if (!enable_in || stop_in) begin
      q_nxt.st   = R_IDLE;
      q_nxt.pull = 1'b0;
    end else if (start_in) begin
      // A repeated start also lands here
      q_nxt.st   = R_ADDR;
      q_nxt.cnt  = 3'h0;
      q_nxt.full = 1'b0;
      q_nxt.pull = 1'b0;
      q_nxt.stat = 4'h0;
    end else begin
      case (q_r.st)
        R_ADDR, R_RX: begin
          if (scl_rise_in) begin
            q_nxt.sh   = {q_r.sh[6:0], sda_in};
            q_nxt.cnt  = q_r.cnt + 3'h1;
            q_nxt.full = (q_r.cnt == 3'h7);
          end else if (scl_fall_in && q_r.full) begin
            q_nxt.full = 1'b0;
            if (q_r.st == R_RX) begin
              q_nxt.rx           = q_r.sh;
              q_nxt.stb          = 1'b1;
              q_nxt.stat[SS_RREQ] = 1'b1;
              q_nxt.stat[SS_FBR]  = q_r.first;
              q_nxt.first        = 1'b0;
              q_nxt.pull         = ackd;
              q_nxt.st           = R_RACK;
            end else if (q_r.sh[7:1] == own1_in || q_r.sh[7:1] == own2_in) begin
              q_nxt.stat[SS_OWN2] = (q_r.sh[7:1] != own1_in);
              q_nxt.pull          = ackd;
              q_nxt.st            = R_AACK;
            end else begin
              q_nxt.st = R_IDLE;
            end
          end
        end
        R_AACK: begin
          if (scl_fall_in && q_r.sh[0]) begin
            q_nxt.st            = R_TX;
            q_nxt.sh            = tx_byte_in;
            q_nxt.pull          = ~tx_byte_in[7];
            q_nxt.cnt           = 3'h0;
            q_nxt.stat[SS_TREQ] = 1'b1;
          end else if (scl_fall_in) begin
            q_nxt.st    = R_RX;
            q_nxt.pull  = 1'b0;
            q_nxt.cnt   = 3'h0;
            q_nxt.first = 1'b1;
          end
        end
        R_RACK: begin
          if (scl_fall_in) begin
            q_nxt.st   = R_RX;
            q_nxt.pull = 1'b0;
            q_nxt.cnt  = 3'h0;
          end
        end
        R_TX: begin
          if (scl_fall_in && q_r.cnt == 3'h7) begin
            q_nxt.st   = R_TACK;
            q_nxt.pull = 1'b0;
          end else if (scl_fall_in) begin
            q_nxt.sh   = {q_r.sh[6:0], 1'b0};
            q_nxt.pull = ~q_r.sh[6];
            q_nxt.cnt  = q_r.cnt + 3'h1;
          end
        end
        R_TACK: begin
          // A refusal by the master ends the read
          if (scl_rise_in) begin
            q_nxt.full = ~sda_in;
          end else if (scl_fall_in && q_r.full) begin
            q_nxt.st   = R_TX;
            q_nxt.sh   = tx_byte_in;
            q_nxt.pull = ~tx_byte_in[7];
            q_nxt.cnt  = 3'h0;
            q_nxt.full = 1'b0;
          end else if (scl_fall_in) begin
            q_nxt.st = R_IDLE;
          end
        end
        default: begin
          q_nxt.st = R_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_r <= '{st: R_IDLE, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sda_pull_out = q_r.pull;
  assign rx_byte_out  = q_r.rx;
  assign rx_stb_out   = q_r.stb;
  assign status_out   = q_r.stat;
endmodule // imsc_resp
`default_nettype wire

// ==== test/imsc_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module imsc_top_asserts
  import imsc_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        resetn_in,
  // Register bus
  input wire logic [5:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // Interrupt and pins
  input wire logic        irq_out,
  input wire logic        scl_out_out,
  input wire logic        sda_out_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  logic             ok;      // Access taken at this edge
  logic [5:0]       wa;      // Word address, as the design decodes it
  logic [IRQ_W-1:0] mask_r;  // Shadow of the enable mask
  assign ok = !avs_waitrequest_out;
  assign wa = {avs_address_in[5:2], 2'b00};
  ////////////////////////////////////////////////////////////////////////////////
  // Mask shadow follows accepted writes only
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) mask_r <= RST_MASK;
    else if (ok && avs_write_in && avs_byteenable_in[0] && wa == OFS_IMASK)
      mask_r <= avs_writedata_in[IRQ_W-1:0];
  end
  ////////////////////////////////////////////////////////////////////////////////
  wait_one_a: assert property ((avs_read_in || avs_write_in) && !ok |=> ok) else $error("Answer late");
  wait_pulse_a: assert property (ok |=> !ok) else $error("Answer too long");
  line_upper_a: assert property (ok && avs_read_in && wa == OFS_LINE |->
    avs_readdata_out[31:2] == 30'h0) else $error("Line bits above 1 set");
  mask_back_a: assert property (ok && avs_read_in && wa == OFS_IMASK |->
    avs_readdata_out == 32'(mask_r)) else $error("Mask readback wrong");
  irq_off_a: assert property (mask_r == 3'h0 [*2] |-> !irq_out) else $error("Masked irq");
  irq_on_a: assert property ($rose(irq_out) |-> mask_r != 3'h0) else $error("Irq unmasked");
  unmapped_zero_a: assert property (ok && avs_read_in && wa > OFS_SSTAT |->
    avs_readdata_out == 32'h0) else $error("Unmapped read not zero");
  drain_only_a: assert property (!scl_out_out && !sda_out_out) else $error("Pin driven high");
  // Main scenarios
  cover property ($rose(irq_out));
  cover property (ok && avs_read_in && avs_address_in == OFS_ISTAT);
  cover property (ok && avs_read_in && avs_address_in == OFS_LINE);
endmodule // imsc_top_asserts
bind imsc_top imsc_top_asserts imsc_top_asserts_inst (.clk_sys_in, .resetn_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .irq_out, .scl_out_out, .sda_out_out);
`default_nettype wire

// ==== test/imsc_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far party on the wire: pull-ups plus a device that may hold either line low
module imsc_far_model (
  // Our pulls
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  // Far party pulls
  input wire logic hold_scl_in,
  input wire logic hold_sda_in,
  // Wire levels
  output logic     scl_lvl_out,
  output logic     sda_lvl_out
);
  // Wired-AND: a released line floats up to one
  assign scl_lvl_out = !(scl_oe_in || hold_scl_in);
  assign sda_lvl_out = !(sda_oe_in || hold_sda_in);
endmodule // imsc_far_model
`default_nettype wire

// ==== test/imsc_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module imsc_top_bench
  import imsc_pkg::*;
;
  logic        clk_sys_in = 1'b0, resetn_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [5:0]  avs_address_in = 6'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic        avs_waitrequest_out, irq_out, scl_in, scl_out_out, scl_oe_out, sda_in, sda_out_out, sda_oe_out;
  logic        hold_scl = 1'b0, hold_sda = 1'b0;  // Far party pulls
  int          fails = 0, num_checks = 0;
  initial forever #12.5 clk_sys_in = !clk_sys_in;
  // Small quarter count: one bus period is 32 clocks; shorter quarters race the pin filters
  imsc_top #(.QTR_CYC_P(8)) imsc_top_inst (.clk_sys_in, .resetn_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hF), .avs_readdata_out, .avs_waitrequest_out,
    .irq_out, .scl_in, .scl_out_out, .scl_oe_out, .sda_in, .sda_out_out, .sda_oe_out);
  imsc_far_model imsc_far_model_inst (.scl_oe_in(scl_oe_out), .sda_oe_in(sda_oe_out), .hold_scl_in(hold_scl),
    .hold_sda_in(hold_sda), .scl_lvl_out(scl_in), .sda_lvl_out(sda_in));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One bus access; a read compares its data with d
  task acc(input logic rd, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= rd;
    avs_write_in <= !rd;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    if (rd) chk(avs_readdata_out, d);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task settle;
    repeat (8) @(posedge clk_sys_in);  // Line filters need a few clocks
  endtask
  task give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    fails++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    settle;
    acc(1'b1, OFS_IMASK, 32'h0);
    acc(1'b1, OFS_LINE, 32'h3);
    acc(1'b1, 6'h3C, 32'h0);
    acc(1'b0, OFS_TADDR, 32'hA7);
    acc(1'b1, OFS_TADDR, 32'hA7);
    acc(1'b0, OFS_SADDR, 32'h15);
    acc(1'b0, OFS_SADDR, 32'hAA);
    acc(1'b1, OFS_SADDR, 32'h2A15);
    acc(1'b0, OFS_SCTRL, 32'h6);
    acc(1'b1, OFS_SCTRL, 32'h6);
    hold_sda <= 1'b1;
    settle;
    acc(1'b1, OFS_LINE, 32'h1);
    hold_scl <= 1'b1;
    settle;
    acc(1'b1, OFS_LINE, 32'h0);
    hold_scl <= 1'b0;
    hold_sda <= 1'b0;
    settle;
    // Timeout of 16 bus periods, 512 clocks, give or take one period
    acc(1'b0, OFS_IMASK, 32'h1);
    acc(1'b0, OFS_TMO, 32'h1);
    hold_scl <= 1'b1;
    repeat (480) @(posedge clk_sys_in);
    chk({31'h0, irq_out}, 32'h0);
    for (int i = 0; i < 40 && irq_out !== 1'b1; i++) @(posedge clk_sys_in);
    chk({31'h0, irq_out}, 32'h1);
    hold_scl <= 1'b0;
    acc(1'b0, OFS_IMASK, 32'h0);
    repeat (2) @(posedge clk_sys_in);
    chk({31'h0, irq_out}, 32'h0);
    acc(1'b0, OFS_MCTRL, 32'h2);
    acc(1'b1, OFS_ISTAT, 32'h0);
    acc(1'b0, OFS_MCTRL, 32'h0);
    acc(1'b1, OFS_ISTAT, 32'h1);
    acc(1'b1, OFS_ISTAT, 32'h0);
    // Loopback: the initiator writes 0x5A to our own responder at primary address 0x15
    acc(1'b0, OFS_SCTRL, 32'h1);
    acc(1'b0, OFS_TADDR, 32'h2A);
    acc(1'b0, OFS_MDATA, 32'h5A);
    acc(1'b0, OFS_IMASK, 32'h2);
    acc(1'b0, OFS_MCTRL, 32'h1);
    for (int i = 0; i < 1000 && irq_out !== 1'b1; i++) @(posedge clk_sys_in);
    chk({31'h0, irq_out}, 32'h1);
    acc(1'b1, OFS_MCTRL, 32'h0);
    acc(1'b1, OFS_SDATA, 32'h5A);
    acc(1'b1, OFS_SSTAT, 32'h5);
    acc(1'b0, OFS_ISTAT, 32'h2);
    acc(1'b1, OFS_ISTAT, 32'h4);
    give_verdict;
  end
endmodule // imsc_top_bench
`default_nettype wire
